//--- src/bme_flags.sv
`timescale 1ns/1ps
`default_nettype none
module bme_flags
	import bme_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic upd,
	input wire logic [7:0] upd_byte,
	input wire logic sw_we,
	input wire logic [7:0] sw_wdata,
	output logic [7:0] condition_flags_reg
);

	// Condition flag storage
	typedef struct packed {
		logic [7:0] condition_flags_reg;
	} bme_fl_type;

	bme_fl_type r; // Current flags
	bme_fl_type n; // Next flags

	assign condition_flags_reg = r.condition_flags_reg;

	// Flag update from the moved byte
	always_comb begin
		n = r;
		if (sw_we)
			n.condition_flags_reg = sw_wdata;
		if (upd) begin
			n.condition_flags_reg[CCR_N] = upd_byte[7];
			n.condition_flags_reg[CCR_Z] = (upd_byte == 8'h00);
			n.condition_flags_reg[CCR_V] = 1'b0;
			n.condition_flags_reg[CCR_C] = r.condition_flags_reg[CCR_C];
		end
	end

	// State register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			r <= '{condition_flags_reg: CCR_RST};
		else
			r <= n;
	end

endmodule // bme_flags
`default_nettype wire

//--- src/bme_pkg.sv
package bme_pkg;

	// Register offsets on the APB side
	localparam logic [7:0] ADDR_CMD = 8'h00;
	localparam logic [7:0] ADDR_OPND = 8'h04;
	localparam logic [7:0] ADDR_STAT = 8'h08;
	localparam logic [7:0] ADDR_CCR = 8'h0c;
	localparam logic [7:0] ADDR_GREG = 8'h10;
	localparam logic [7:0] ADDR_GREG_LAST = 8'h2c;

	// Command word fields
	localparam int CMD_MODE_LSB = 0;
	localparam int CMD_STORE_BIT = 4;
	localparam int CMD_BSEL_LSB = 8;
	localparam int CMD_BSEL2_LSB = 12;
	localparam int CMD_PTR_LSB = 16;

	// Status word fields
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_BAD_BIT = 1;
	localparam int STAT_BYTE_LSB = 8;

	// Condition flag positions
	localparam int CCR_C = 0;
	localparam int CCR_V = 1;
	localparam int CCR_Z = 2;
	localparam int CCR_N = 3;

	// Reset values
	localparam logic [7:0] CCR_RST = 8'h00;
	localparam logic [31:0] GREG_RST = 32'h0000_0000;

	// Addressing modes
	localparam logic [3:0] MODE_IMM = 4'h0;
	localparam logic [3:0] MODE_REG = 4'h1;
	localparam logic [3:0] MODE_IND = 4'h2;
	localparam logic [3:0] MODE_DISP16 = 4'h3;
	localparam logic [3:0] MODE_DISP24 = 4'h4;
	localparam logic [3:0] MODE_AUTO = 4'h5;
	localparam logic [3:0] MODE_ABS = 4'h6;

	// Pointer step for auto modes
	localparam logic [31:0] PTR_STEP = 32'h0000_0001;

	// Execution states
	typedef enum logic [1:0] {BME_IDLE, BME_EXEC, BME_MEM} bme_state_type;

	// Byte selector: bit 3 picks low byte, bits 2:0 the register
	function automatic logic [7:0] byte_get(input logic [31:0] w, input logic [3:0] sel);
		byte_get = sel[3] ? w[7:0] : w[15:8];
	endfunction

	function automatic logic [31:0] byte_put(input logic [31:0] w, input logic [3:0] sel,
		input logic [7:0] b);
		byte_put = sel[3] ? {w[31:8], b} : {w[31:16], b, w[7:0]};
	endfunction

	// General register window decode
	function automatic logic greg_hit(input logic [7:0] a);
		greg_hit = (a[1:0] == 2'h0) && (a >= ADDR_GREG) && (a <= ADDR_GREG_LAST);
	endfunction

	function automatic logic [2:0] greg_idx(input logic [7:0] a);
		logic [7:0] d;
		d = a - ADDR_GREG;
		greg_idx = d[4:2];
	endfunction

endpackage

//--- src/bme_regfile.sv
`timescale 1ns/1ps
`default_nettype none
module bme_regfile
	import bme_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [3:0] rsel_a,
	output logic [7:0] rbyte_a,
	input wire logic [3:0] rsel_b,
	output logic [7:0] rbyte_b,
	input wire logic [2:0] ridx_p,
	output logic [31:0] rword_p,
	input wire logic [2:0] ridx_w,
	output logic [31:0] rword_w,
	input wire logic bwe,
	input wire logic [3:0] bsel,
	input wire logic [7:0] bdata,
	input wire logic wwe,
	input wire logic [2:0] widx,
	input wire logic [31:0] wdata
);

	// Eight wide registers, each E half over high and low bytes
	typedef struct packed {
		logic [7:0][31:0] er;
	} bme_rf_type;

	bme_rf_type r; // Current state
	bme_rf_type n; // Next state
	logic [31:0] chk_old; // Word before a byte write
	logic [31:0] chk_mask; // Untouched lanes
	logic [2:0] chk_idx; // Register written
	logic chk_v; // Check armed

	// Read ports
	assign rbyte_a = byte_get(r.er[rsel_a[2:0]], rsel_a);
	assign rbyte_b = byte_get(r.er[rsel_b[2:0]], rsel_b);
	assign rword_p = r.er[ridx_p];
	assign rword_w = r.er[ridx_w];

	// Byte lane merge, then whole word write wins
	always_comb begin
		n = r;
		if (bwe)
			n.er[bsel[2:0]] = byte_put(r.er[bsel[2:0]], bsel, bdata);
		if (wwe)
			n.er[widx] = wdata;
	end

	// State register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			r <= '{er: '{default: GREG_RST}};
		else
			r <= n;
	end

	// Helper capture for the lane check
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			chk_old <= 32'h0;
			chk_mask <= 32'h0;
			chk_idx <= 3'h0;
			chk_v <= 1'b0;
		end else begin
			chk_old <= r.er[bsel[2:0]];
			chk_mask <= bsel[3] ? 32'hffff_ff00 : 32'hffff_00ff;
			chk_idx <= bsel[2:0];
			chk_v <= bwe && !(wwe && widx == bsel[2:0]);
		end
	end

	property p_lane_keep;
		@(posedge clk) disable iff (!rstn)
		chk_v |-> ((r.er[chk_idx] & chk_mask) == (chk_old & chk_mask));
	endproperty
	a_lane_keep: assert property (p_lane_keep)
		else $error("byte write disturbed other lanes");

endmodule // bme_regfile
`default_nettype wire

//--- src/bme_top.sv
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module bme_top
	import bme_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic mem_req,
	output logic mem_we,
	output logic [31:0] mem_addr,
	output logic [7:0] mem_wdata,
	input wire logic [7:0] mem_rdata,
	input wire logic mem_ack
);

	// Whole controller state
	typedef struct packed {
		bme_state_type st;
		logic [31:0] opnd;
		logic [3:0] mode;
		logic store;
		logic [3:0] bsel;
		logic [3:0] bsel2;
		logic [2:0] pidx;
		logic mem_req;
		logic mem_we;
		logic [31:0] mem_addr;
		logic [7:0] mem_wdata;
		logic [31:0] prdata;
		logic slverr;
		logic bad_cmd;
		logic [7:0] last_byte;
	} bme_main_type;

	localparam bme_main_type MAIN_RST = '{
		st: BME_IDLE,
		mode: MODE_IMM,
		default: '0
	};

	bme_main_type r; // Current state
	bme_main_type n; // Next state
	logic acc; // APB access phase
	logic upd; // Flag update strobe
	logic [7:0] upd_byte; // Byte moved
	logic bwe; // Byte register write
	logic [7:0] bdata; // Byte write data
	logic wwe; // Word register write
	logic [2:0] widx; // Word write index
	logic [31:0] wdata; // Word write data
	logic ccr_we; // Software flag write
	logic [7:0] rbyte_a; // Store source or load target
	logic [7:0] rbyte_b; // Register-to-register source
	logic [31:0] rword_p; // Pointer register
	logic [31:0] rword_w; // APB view of a register
	logic [7:0] condition_flags_reg; // Condition flags
	logic [31:0] ea; // Effective address
	logic cmd_bad; // Undefined command

	// Register bank
	bme_regfile u_rf (
		.clk(pclk),
		.rstn(presetn),
		.rsel_a(r.bsel),
		.rbyte_a(rbyte_a),
		.rsel_b(r.bsel2),
		.rbyte_b(rbyte_b),
		.ridx_p(r.pidx),
		.rword_p(rword_p),
		.ridx_w(greg_idx(paddr)),
		.rword_w(rword_w),
		.bwe(bwe),
		.bsel(r.bsel),
		.bdata(bdata),
		.wwe(wwe),
		.widx(widx),
		.wdata(wdata)
	);

	// Condition flags
	bme_flags u_fl (
		.clk(pclk),
		.rstn(presetn),
		.upd(upd),
		.upd_byte(upd_byte),
		.sw_we(ccr_we),
		.sw_wdata(pwdata[7:0]),
		.condition_flags_reg(condition_flags_reg)
	);

	// Handshake and data outputs
	assign acc = psel && penable;
	assign pready = acc;
	assign pslverr = acc && r.slverr;
	assign prdata = r.prdata;
	assign mem_req = r.mem_req;
	assign mem_we = r.mem_we;
	assign mem_addr = r.mem_addr;
	assign mem_wdata = r.mem_wdata;

	// Invalid mode, or a store to a non-memory operand
	assign cmd_bad = (r.mode > MODE_ABS) || (r.store && r.mode <= MODE_REG);

	// Effective address from the whole pointer, or the operand in MODE_ABS
	always_comb begin
		ea = rword_p;
		case (r.mode)
			MODE_IND: ea = rword_p;
			MODE_DISP16: ea = rword_p + {{16{r.opnd[15]}}, r.opnd[15:0]};
			MODE_DISP24: ea = rword_p + {{8{r.opnd[23]}}, r.opnd[23:0]};
			MODE_AUTO: ea = r.store ? rword_p - PTR_STEP : rword_p;
			MODE_ABS: ea = r.opnd;
			default: ea = rword_p;
		endcase
	end

	// Bus slave and execution sequencer
	always_comb begin
		n = r;
		upd = 1'b0;
		upd_byte = 8'h00;
		bwe = 1'b0;
		bdata = 8'h00;
		wwe = 1'b0;
		widx = r.pidx;
		wdata = 32'h0;
		ccr_we = 1'b0;
		// Setup cycle: read data and error decided here
		if (psel && !penable) begin
			n.prdata = 32'h0;
			n.slverr = 1'b0;
			if (pwrite) begin
				// Writes refused while busy
				if (r.st != BME_IDLE)
					n.slverr = 1'b1;
				else if (!(paddr == ADDR_CMD || paddr == ADDR_OPND ||
					paddr == ADDR_CCR || greg_hit(paddr)))
					n.slverr = 1'b1;
			end else begin
				if (paddr == ADDR_CMD)
					n.prdata = {12'h000, 1'b0, r.pidx, r.bsel2, r.bsel, 3'h0, r.store, r.mode};
				else if (paddr == ADDR_OPND)
					n.prdata = r.opnd;
				else if (paddr == ADDR_STAT) begin
					n.prdata[STAT_BUSY_BIT] = (r.st != BME_IDLE);
					n.prdata[STAT_BAD_BIT] = r.bad_cmd;
					n.prdata[STAT_BYTE_LSB +: 8] = r.last_byte;
				end else if (paddr == ADDR_CCR)
					n.prdata = {24'h000000, condition_flags_reg};
				else if (greg_hit(paddr))
					n.prdata = rword_w;
				else
					n.slverr = 1'b1;
			end
		end
		// Access cycle: accepted writes take effect
		if (acc && pwrite && !r.slverr) begin
			if (paddr == ADDR_CMD) begin
				n.mode = pwdata[CMD_MODE_LSB +: 4];
				n.store = pwdata[CMD_STORE_BIT];
				n.bsel = pwdata[CMD_BSEL_LSB +: 4];
				n.bsel2 = pwdata[CMD_BSEL2_LSB +: 4];
				n.pidx = pwdata[CMD_PTR_LSB +: 3];
				n.bad_cmd = 1'b0;
				n.st = BME_EXEC;
			end else if (paddr == ADDR_OPND)
				n.opnd = pwdata;
			else if (paddr == ADDR_CCR)
				ccr_we = 1'b1;
			else if (greg_hit(paddr)) begin
				wwe = 1'b1;
				widx = greg_idx(paddr);
				wdata = pwdata;
			end
		end
		// Instruction sequencing
		case (r.st)
			BME_IDLE: begin
				// Waiting for a command
			end
			BME_EXEC: begin
				if (cmd_bad) begin
					// Undefined: nothing moved, flags kept
					n.bad_cmd = 1'b1;
					n.st = BME_IDLE;
				end else if (r.mode == MODE_IMM || r.mode == MODE_REG) begin
					bdata = (r.mode == MODE_IMM) ? r.opnd[7:0] : rbyte_b;
					bwe = 1'b1;
					upd = 1'b1;
					upd_byte = bdata;
					n.last_byte = bdata;
					n.st = BME_IDLE;
				end else begin
					// Start one byte memory access
					n.mem_addr = ea;
					n.mem_req = 1'b1;
					n.mem_we = r.store;
					n.mem_wdata = rbyte_a;
					// Pre-decrement store updates pointer first
					if (r.store && r.mode == MODE_AUTO) begin
						wwe = 1'b1;
						wdata = ea;
					end
					n.st = BME_MEM;
				end
			end
			BME_MEM: begin
				if (mem_ack) begin
					n.mem_req = 1'b0;
					n.mem_we = 1'b0;
					upd_byte = r.store ? r.mem_wdata : mem_rdata;
					upd = 1'b1;
					n.last_byte = upd_byte;
					if (!r.store) begin
						bwe = 1'b1;
						bdata = mem_rdata;
					end
					if (!r.store && r.mode == MODE_AUTO) begin
						wwe = 1'b1;
						wdata = rword_p + PTR_STEP;
					end
					n.st = BME_IDLE;
				end
			end
			default: n.st = BME_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			r <= MAIN_RST;
		else
			r <= n;
	end

	// Checks on the moves
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	property p_nz_follow;
		upd |=> (condition_flags_reg[CCR_N] == r.last_byte[7]) && (condition_flags_reg[CCR_Z] == (r.last_byte == 8'h00));
	endproperty
	a_nz_follow: assert property (p_nz_follow)
		else $error("sign or zero flag wrong after move");

	property p_carry_kept;
		upd && !ccr_we |=> (condition_flags_reg[CCR_C] == $past(condition_flags_reg[CCR_C])) &&
			(condition_flags_reg[7:4] == $past(condition_flags_reg[7:4]));
	endproperty
	a_carry_kept: assert property (p_carry_kept)
		else $error("unlisted flag changed by move");

	property p_v_clear;
		upd |=> !condition_flags_reg[CCR_V];
	endproperty
	a_v_clear: assert property (p_v_clear)
		else $error("overflow flag not cleared");

	property p_ind_addr;
		(r.st == BME_EXEC && !cmd_bad && r.mode == MODE_IND) |=>
			mem_req && (mem_addr == $past(rword_p));
	endproperty
	a_ind_addr: assert property (p_ind_addr)
		else $error("indirect address not the full pointer");

	property p_postinc;
		(r.st == BME_MEM && mem_ack && !r.store && r.mode == MODE_AUTO) |=>
			(rword_p == $past(rword_p) + PTR_STEP) && (r.last_byte == $past(mem_rdata));
	endproperty
	a_postinc: assert property (p_postinc)
		else $error("post-increment pointer wrong");

	property p_store_hold;
		(mem_req && mem_we && !mem_ack) |=>
			mem_req && $stable(mem_addr) && $stable(mem_wdata);
	endproperty
	a_store_hold: assert property (p_store_hold)
		else $error("store request changed before ack");

	property p_store_src;
		(r.st == BME_MEM && r.store && mem_ack) |=>
			(rbyte_a == $past(rbyte_a)) && !mem_req ##1 (r.st == BME_IDLE);
	endproperty
	a_store_src: assert property (p_store_src)
		else $error("store altered its source register");

	cover property (r.st == BME_MEM && mem_ack && !r.store && r.mode == MODE_AUTO);
	cover property (r.st == BME_MEM && mem_ack && r.store);
	cover property (r.st == BME_EXEC && r.mode == MODE_REG && !cmd_bad);
	cover property (r.st == BME_EXEC && cmd_bad);

endmodule // bme_top
`default_nettype wire

//--- verification/bme_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// Byte memory on the far side of the operand bus
module bme_mem_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	input wire logic [3:0] max_wait,
	output logic [7:0] mem_rdata,
	output logic mem_ack
);
	// Written bytes; unwritten ones follow a pattern of all 32 address bits
	logic [7:0] mem_m [logic [31:0]];
	// Wait cycles spent on the current request
	int cnt;

	// Content lookup for the bench
	function automatic logic [7:0] peek(input logic [31:0] a);
		peek = mem_m.exists(a) ? mem_m[a] : (a[7:0] ^ a[15:8] ^ a[23:16] ^ a[31:24] ^ 8'h3c);
	endfunction

	// Answer after max_wait cycles; data line toggles when not answering
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_ack <= 1'b0;
			mem_rdata <= 8'h00;
			cnt <= 0;
		end else begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			if (mem_ack && mem_req) begin
				// Completion edge: a store lands here
				if (mem_we)
					mem_m[mem_addr] = mem_wdata;
				cnt <= 0;
			end else if (mem_req) begin
				if (cnt >= int'(max_wait)) begin
					mem_ack <= 1'b1;
					mem_rdata <= peek(mem_addr);
				end else
					cnt <= cnt + 1;
			end
		end
	end
endmodule // bme_mem_model
`default_nettype wire

//--- verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench import bme_pkg::*;;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, mem_addr;
	logic pready, pslverr, mem_req, mem_we, mem_ack;
	logic [7:0] mem_wdata, mem_rdata;
	logic [3:0] max_wait = 0;
	int err_total = 0, checks_done = 0, cyc = 0;
	// Reference state
	logic [31:0] m_reg [8] = '{default: 32'h0};
	logic [7:0] m_ccr = 8'h00, m_last = 8'h00;
	logic m_bad = 1'b0;

	bme_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
	bme_mem_model mem_u (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_we(mem_we),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .max_wait(max_wait),
		.mem_rdata(mem_rdata), .mem_ack(mem_ack));

	initial forever #25 pclk = ~pclk;

	// Hang guard
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 60000) begin
			err_total++;
			close_out();
		end
	end

	task automatic close_out();
		if (err_total == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			$display("BAD %s exp %h got %h", nm, e, g);
			err_total++;
		end
	endtask

	// One APB transfer: setup, access held until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// Wait for the answer; only the hang guard ends this
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Compare registers, flags and status with the reference
	task automatic cmp_all();
		logic [31:0] d;
		logic e;
		for (int i = 0; i < 8; i++) begin
			apb(0, ADDR_GREG + 8'(4 * i), 0, d, e);
			chk("greg", m_reg[i], d);
		end
		apb(0, ADDR_CCR, 0, d, e);
		chk("ccr", {24'h0, m_ccr}, d);
		apb(0, ADDR_STAT, 0, d, e);
		chk("stat", {16'h0, m_last, 6'h0, m_bad, 1'b0}, d & 32'h0000ff03);
	endtask

	// Issue one move, wait for idle, update reference, compare
	task automatic run_op(input logic [3:0] md, input logic st, input logic [3:0] bs,
		input logic [3:0] bs2, input logic [2:0] pr, input logic [31:0] op, input logic pb);
		logic [31:0] a, d;
		logic [7:0] b, nb;
		logic e, ok;
		int n;
		ok = !(md > MODE_ABS || (st && md < MODE_IND));
		a = m_reg[pr];
		if (md == MODE_DISP16)
			a = a + {{16{op[15]}}, op[15:0]};
		if (md == MODE_DISP24)
			a = a + {{8{op[23]}}, op[23:0]};
		if (md == MODE_AUTO && st)
			a = a - 32'h1;
		if (md == MODE_ABS)
			a = op;
		b = mem_u.peek(a);
		nb = mem_u.peek(a + 32'h1);
		if (md == MODE_IMM)
			b = op[7:0];
		if (md == MODE_REG)
			b = bs2[3] ? m_reg[bs2[2:0]][7:0] : m_reg[bs2[2:0]][15:8];
		if (st)
			b = bs[3] ? m_reg[bs[2:0]][7:0] : m_reg[bs[2:0]][15:8];
		apb(1, ADDR_OPND, op, d, e);
		apb(1, ADDR_CMD, {13'h0, pr, bs2, bs, 3'h0, st, md}, d, e);
		if (pb) begin
			apb(1, ADDR_CCR, 32'hff, d, e);
			chk("busy refusal", 1, e);
		end
		n = 0;
		d = 32'h1;
		while (d[0] !== 1'b0 && n < 40) begin
			apb(0, ADDR_STAT, 0, d, e);
			n++;
		end
		chk("busy clear", 0, {31'h0, d[0]});
		if (ok) begin
			if (!st && bs[3])
				m_reg[bs[2:0]][7:0] = b;
			if (!st && !bs[3])
				m_reg[bs[2:0]][15:8] = b;
			if (md == MODE_AUTO)
				m_reg[pr] = st ? a : m_reg[pr] + 32'h1;
			m_ccr = {m_ccr[7:4], b[7], b == 8'h00, 1'b0, m_ccr[0]};
			m_last = b;
		end
		m_bad = !ok;
		if (st && ok) begin
			chk("mem byte", {24'h0, b}, {24'h0, mem_u.peek(a)});
			chk("mem next", {24'h0, nb}, {24'h0, mem_u.peek(a + 32'h1)});
		end
		cmp_all();
	endtask

	// Main sequence
	initial begin
		logic [31:0] d;
		logic e, st;
		logic [3:0] md, bs;
		void'($urandom(12));
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		cmp_all();
		apb(0, 8'h30, 0, d, e);
		chk("unmapped err", 1, e);
		chk("unmapped data", 0, d);
		apb(1, 8'h11, 0, d, e);
		chk("misaligned err", 1, e);
		for (int i = 0; i < 8; i++) begin
			m_reg[i] = $urandom;
			apb(1, ADDR_GREG + 8'(4 * i), m_reg[i], d, e);
		end
		m_ccr = 8'($urandom);
		apb(1, ADDR_CCR, {24'h0, m_ccr}, d, e);
		// Zero and sign boundaries
		run_op(MODE_IMM, 0, 4'h8, 4'h0, 3'h0, 32'h0, 0);
		run_op(MODE_IMM, 0, 4'h1, 4'h0, 3'h0, 32'h80, 0);
		// Pointer wraps across the full width
		m_reg[3] = 32'hffff_ffff;
		apb(1, ADDR_GREG + 8'hc, m_reg[3], d, e);
		run_op(MODE_AUTO, 0, 4'h9, 4'h0, 3'h3, 32'h0, 0);
		// Write while busy is refused
		max_wait <= 4'h8;
		run_op(MODE_ABS, 0, 4'hc, 4'h0, 3'h0, $urandom, 1);
		for (int i = 0; i < 70; i++) begin
			md = (i < 14) ? 4'(i % 7) : 4'($urandom_range(7, 0));
			st = (i < 14) ? (i >= 7) : 1'($urandom);
			if (!st && md == 4'h7)
				md = MODE_ABS;
			bs = 4'($urandom);
			max_wait <= 4'($urandom_range(3, 0));
			run_op(md, st, bs, 4'($urandom), 3'(bs[2:0] + $urandom_range(7, 1)),
				$urandom, 0);
		end
		close_out();
	end
endmodule // testbench
`default_nettype wire
